// [core/gio_pkg.sv]
// Package for the general I/O port: register map, mode codes, carriers.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`default_nettype none
package gio_pkg;
	localparam int unsigned NPINS = 8;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_DIR = 8'h04;
	localparam logic [7:0] ADDR_OPT = 8'h08;
	localparam logic [7:0] ADDR_SENS = 8'h0C;
	localparam logic [7:0] ADDR_GROUP = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_SENS = 2'h0;
	localparam logic [7:0] RST_GROUP = 8'h00;
	localparam int unsigned SENS_W = 2;
	localparam int unsigned NGROUPS = 2;
	// ****************************************
	// Sensitivity codes
	// ****************************************
	typedef enum logic [1:0] {
		SENS_NONE = 2'b00,
		SENS_RISE = 2'b01,
		SENS_FALL = 2'b10,
		SENS_BOTH = 2'b11
	} gio_sens_t;
	// Per-pin alternate function request
	typedef struct packed {
		logic [7:0] en;
		logic [7:0] is_out;
		logic [7:0] out_val;
		logic [7:0] push_pull;
	} gio_alt_t;
	// Pad drive
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_en;
	} gio_pad_t;
endpackage
`default_nettype wire

// [core/gio_sync.sv]
// Two-flop synchroniser bank for the pin inputs.
// Assumes the inputs are asynchronous to CLK_SYS_I.
`default_nettype none
module gio_sync #(
	parameter int unsigned W = 8
) (
	input wire logic clk_i, // Core clock
	input wire logic rst_i, // Async reset, high
	input wire logic ce_i, // Clock enable
	input wire logic [W-1:0] d_i, // Async inputs
	output logic [W-1:0] q_o // Synchronised
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else if (ce_i) begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [core/gio_port.sv]
// General I/O port: eight pins, data/direction/option registers, external
// interrupt groups with edge sensitivity, alternate-function override.
// Assumes classic Wishbone master on the core clock; pads resolve out/oe.
// Behaviour
// - Eight pins, each independently input, input with interrupt, or output.
// - Bit n of direction, option and data registers belongs to pin n.
// - Direction 0 makes pin input; data read returns the pin level.
// - Input option bit picks floating or pull-up, and interrupt enable.
// - Data write in input mode only updates the latch; pin stays undriven.
// - Input-with-interrupt pins raise an external request independently.
// - Each vector serves a pin group; detected edges are ORed together.
// - Group request latch is hidden, cleared on vector fetch.
// - Changing a group's sensitivity bits clears its pending request.
// - Direction 1 makes pin output from latch; reads return latch.
// - Output option picks push-pull or open-drain; open-drain 1 floats.
// - Enabled alternate function overrides standard pin programming.
// - Peripheral output forces output mode; peripheral picks drive type.
// - Peripheral input needs input mode; pin still readable via data.
// - Input mode with alternate output drive: data read gives alt output.
// - Output mode with alternate input: peripheral receives latch value.
// - Direction/option 00 float, 01 pull-up/irq, 10 open-drain, 11 push-pull.
// - Sensitivity 01 rising, 10 falling, 11 both edges.
`default_nettype none
module gio_port #(
	parameter int unsigned NPINS = gio_pkg::NPINS,
	parameter logic [7:0] IRQ_CAPABLE = 8'hFF // Pins that support interrupt
) (
	input wire logic CLK_SYS_I, // 20 MHz core clock
	input wire logic SYS_RST_I, // Async reset, high
	input wire logic CE_I, // Clock enable, freezes state when low
	// Wishbone slave
	input wire logic WB_CYC_I, // Cycle
	input wire logic WB_STB_I, // Strobe
	input wire logic WB_WE_I, // Write enable
	input wire logic [7:0] WB_ADR_I, // Byte address
	input wire logic [3:0] WB_SEL_I, // Byte selects
	input wire logic [31:0] WB_DAT_I, // Write data
	output logic [31:0] WB_DAT_O, // Read data
	output logic WB_ACK_O, // Acknowledge
	output logic WB_ERR_O, // Unmapped address
	// Pads
	input wire logic [7:0] PAD_IN_I, // Pin levels (async)
	output var gio_pkg::gio_pad_t PAD_O, // Drive, enable, pull-up
	// Alternate functions
	input wire gio_pkg::gio_alt_t ALT_I, // Peripheral requests
	output logic [7:0] ALT_IN_O, // Level seen by peripherals
	// Interrupt controller
	input wire logic [1:0] VEC_FETCH_I, // Vector fetch pulse per group
	output logic [1:0] EXT_IRQ_O // Request per group
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] pin_data_latch_q;
	logic [7:0] pin_direction_q;
	logic [7:0] pin_option_q;
	logic [1:0] ext_irq_sensitivity_ctrl_q [gio_pkg::NGROUPS];
	logic [7:0] pin_group_q; // Bit n: pin n belongs to group 1
	logic [7:0] pin_sync;
	logic [7:0] pin_prev_q;
	logic [1:0] irq_pend_q;
	logic [31:0] rd_d;
	logic [31:0] rd_q;
	logic ack_q;
	logic err_q;
	logic req;
	logic wr;
	logic mapped;
	logic [1:0] sens_wr;
	logic [1:0] grp_hit;
	logic [7:0] irq_pin_en;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] pad_out;
	logic [7:0] pad_oe;
	logic [7:0] pad_pull;
	logic [7:0] data_view;
	logic [7:0] wdat;

	gio_sync #(
		.W(8)
	) u_sync (
		.clk_i(CLK_SYS_I),
		.rst_i(SYS_RST_I),
		.ce_i(CE_I),
		.d_i(PAD_IN_I),
		.q_o(pin_sync)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	assign req = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
	assign wr = req && WB_WE_I && WB_SEL_I[0];
	assign wdat = WB_DAT_I[7:0];
	assign mapped = (WB_ADR_I == gio_pkg::ADDR_DATA) || (WB_ADR_I == gio_pkg::ADDR_DIR) ||
		(WB_ADR_I == gio_pkg::ADDR_OPT) || (WB_ADR_I == gio_pkg::ADDR_SENS) ||
		(WB_ADR_I == gio_pkg::ADDR_GROUP) || (WB_ADR_I == gio_pkg::ADDR_STAT);
	assign WB_ACK_O = ack_q;
	assign WB_ERR_O = err_q;
	assign WB_DAT_O = rd_q;

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else if (CE_I) begin
			ack_q <= req && mapped;
			err_q <= req && !mapped;
		end
	end

	// ****************************************
	// Port registers
	// ****************************************
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pin_data_latch_q <= gio_pkg::RST_BYTE;
		end else if (CE_I && wr && WB_ADR_I == gio_pkg::ADDR_DATA) begin
			pin_data_latch_q <= wdat;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pin_direction_q <= gio_pkg::RST_BYTE;
			pin_option_q <= gio_pkg::RST_BYTE;
			pin_group_q <= gio_pkg::RST_GROUP;
		end else if (CE_I && wr) begin
			if (WB_ADR_I == gio_pkg::ADDR_DIR) begin
				pin_direction_q <= wdat;
			end
			if (WB_ADR_I == gio_pkg::ADDR_OPT) begin
				pin_option_q <= wdat;
			end
			if (WB_ADR_I == gio_pkg::ADDR_GROUP) begin
				pin_group_q <= wdat;
			end
		end
	end

	// Sensitivity: group g in bits [2g+1:2g] of its register
	assign sens_wr[0] = wr && WB_ADR_I == gio_pkg::ADDR_SENS &&
		wdat[1:0] != ext_irq_sensitivity_ctrl_q[0];
	assign sens_wr[1] = wr && WB_ADR_I == gio_pkg::ADDR_SENS &&
		wdat[3:2] != ext_irq_sensitivity_ctrl_q[1];

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ext_irq_sensitivity_ctrl_q[0] <= gio_pkg::RST_SENS;
			ext_irq_sensitivity_ctrl_q[1] <= gio_pkg::RST_SENS;
		end else if (CE_I && wr && WB_ADR_I == gio_pkg::ADDR_SENS) begin
			ext_irq_sensitivity_ctrl_q[0] <= wdat[1:0];
			ext_irq_sensitivity_ctrl_q[1] <= wdat[3:2];
		end
	end

	// ****************************************
	// Pin datapath
	// ****************************************
	genvar n;
	generate
		for (n = 0; n < NPINS; n++) begin : g_pin
			logic alt_out;
			logic std_out;
			logic pp;
			logic drv_val;
			assign alt_out = ALT_I.en[n] && ALT_I.is_out[n];
			assign std_out = pin_direction_q[n];
			// Peripheral picks drive type, else option bit
			assign pp = alt_out ? ALT_I.push_pull[n] : pin_option_q[n];
			assign drv_val = alt_out ? ALT_I.out_val[n] : pin_data_latch_q[n];
			assign pad_out[n] = (alt_out || std_out) ? drv_val : 1'b0;
			assign pad_oe[n] = (alt_out || std_out) && (pp || !drv_val);
			// Pull-up only in input mode with option set
			assign pad_pull[n] = !alt_out && !std_out && pin_option_q[n];
			// Read view: latch, alt output, or input level
			assign data_view[n] = std_out ? pin_data_latch_q[n] :
				(alt_out ? ALT_I.out_val[n] : pin_sync[n]);
			// Alt input sees latch while pin is output
			assign ALT_IN_O[n] = std_out ? pin_data_latch_q[n] : pin_sync[n];
			// Input with interrupt: dir 0, option 1, capable pin, alternate function off
			assign irq_pin_en[n] = IRQ_CAPABLE[n] && !std_out && pin_option_q[n] &&
				!ALT_I.en[n];
		end
	endgenerate
	assign PAD_O = {pad_out, pad_oe, pad_pull};

	// ****************************************
	// External interrupts
	// ****************************************
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pin_prev_q <= gio_pkg::RST_BYTE;
		end else if (CE_I) begin
			pin_prev_q <= pin_sync;
		end
	end

	assign rise = pin_sync & ~pin_prev_q;
	assign fall = ~pin_sync & pin_prev_q;

	genvar g;
	generate
		for (g = 0; g < gio_pkg::NGROUPS; g++) begin : g_grp
			logic [7:0] members;
			logic [7:0] evt;
			assign members = (g == 0) ? ~pin_group_q : pin_group_q;
			always_comb begin
				case (gio_pkg::gio_sens_t'(ext_irq_sensitivity_ctrl_q[g]))
					gio_pkg::SENS_RISE: evt = rise;
					gio_pkg::SENS_FALL: evt = fall;
					gio_pkg::SENS_BOTH: evt = rise | fall;
					default: evt = '0;
				endcase
			end
			assign grp_hit[g] = |(evt & members & irq_pin_en);
			// Hidden latch: set wins over fetch, sensitivity change clears
			always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
				if (SYS_RST_I) begin
					irq_pend_q[g] <= 1'b0;
				end else if (CE_I) begin
					if (sens_wr[g]) begin
						irq_pend_q[g] <= 1'b0;
					end else if (grp_hit[g]) begin
						irq_pend_q[g] <= 1'b1;
					end else if (VEC_FETCH_I[g]) begin
						irq_pend_q[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate
	assign EXT_IRQ_O = irq_pend_q;

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rd_d = '0;
		case (WB_ADR_I)
			gio_pkg::ADDR_DATA: rd_d[7:0] = data_view;
			gio_pkg::ADDR_DIR: rd_d[7:0] = pin_direction_q;
			gio_pkg::ADDR_OPT: rd_d[7:0] = pin_option_q;
			gio_pkg::ADDR_SENS: rd_d[3:0] = {ext_irq_sensitivity_ctrl_q[1],
				ext_irq_sensitivity_ctrl_q[0]};
			gio_pkg::ADDR_GROUP: rd_d[7:0] = pin_group_q;
			gio_pkg::ADDR_STAT: rd_d[7:0] = pin_sync;
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			rd_q <= '0;
		end else if (CE_I && req) begin
			rd_q <= rd_d;
		end
	end
endmodule
`default_nettype wire

// [sim/gio_port_sva.sv]
// Checker for the general I/O port, bound to gio_port.
// Assumes single-cycle Wishbone requests and no alternate function on read pins.
`default_nettype none
module gio_port_sva (
	input wire logic CLK_SYS_I, // Clock
	input wire logic SYS_RST_I, // Reset
	input wire logic CE_I, // Enable
	input wire logic WB_CYC_I, // Cycle
	input wire logic WB_STB_I, // Strobe
	input wire logic WB_WE_I, // Write
	input wire logic [7:0] WB_ADR_I, // Address
	input wire logic [3:0] WB_SEL_I, // Selects
	input wire logic [31:0] WB_DAT_I, // Write data
	input wire logic [31:0] WB_DAT_O, // Read data
	input wire logic WB_ACK_O, // Ack
	input wire logic WB_ERR_O, // Error
	input wire logic [7:0] PAD_IN_I, // Pins
	input wire gio_pkg::gio_pad_t PAD_O, // Pad drive
	input wire gio_pkg::gio_alt_t ALT_I, // Alternate
	input wire logic [7:0] ALT_IN_O, // To peripherals
	input wire logic [1:0] VEC_FETCH_I, // Fetch
	input wire logic [1:0] EXT_IRQ_O // Requests
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] dir_q, opt_q, lat_q;
	wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O & CE_I;
	// Shadow copies so pad checks need no peeking inside
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			dir_q <= 8'h00;
			opt_q <= 8'h00;
			lat_q <= 8'h00;
		end else if (req & WB_WE_I & WB_SEL_I[0]) begin
			case (WB_ADR_I)
				gio_pkg::ADDR_DIR: dir_q <= WB_DAT_I[7:0];
				gio_pkg::ADDR_OPT: opt_q <= WB_DAT_I[7:0];
				gio_pkg::ADDR_DATA: lat_q <= WB_DAT_I[7:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (SYS_RST_I);
	ack_one_cycle_a: assert property (WB_ACK_O && CE_I |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	answer_latency_a: assert property (req |=> WB_ACK_O ^ WB_ERR_O)
		else $error("no single answer one cycle after request");
	unmapped_err_a: assert property (req && WB_ADR_I > 8'h14 |=> WB_ERR_O)
		else $error("unmapped address not refused");
	pin_drive_a: assert property (ALT_I.en == 8'h00 |->
		PAD_O.oe == (dir_q & (opt_q | ~lat_q)) && (PAD_O.out & PAD_O.oe) == (lat_q & PAD_O.oe))
		else $error("pad drive does not follow mode");
	pull_up_a: assert property (ALT_I.en == 8'h00 |-> PAD_O.pull_en == (~dir_q & opt_q))
		else $error("pull-up does not follow mode");
	alt_drive_a: assert property (((PAD_O.oe ^ (ALT_I.push_pull | ~ALT_I.out_val))
		& ALT_I.en & ALT_I.is_out) == 8'h00)
		else $error("alternate drive not applied");
	alt_input_a: assert property (((ALT_IN_O ^ lat_q) & dir_q) == 8'h00)
		else $error("peripheral input not latch on output pin");
	data_read_a: assert property (req && !WB_WE_I && WB_ADR_I == 8'h00 && ALT_I.en == 8'h00
		&& PAD_IN_I == $past(PAD_IN_I, 3) |=> WB_DAT_O == {24'h00_0000,
		($past(dir_q) & $past(lat_q)) | (~$past(dir_q) & $past(PAD_IN_I))})
		else $error("data read wrong");
	fetch_clear_a: assert property (VEC_FETCH_I[0] && EXT_IRQ_O[0]
		&& PAD_IN_I == $past(PAD_IN_I, 4) |=> !EXT_IRQ_O[0])
		else $error("request not cleared by fetch");
	cover property (req && WB_WE_I);
	cover property ($rose(EXT_IRQ_O[1]));
	cover property (WB_ERR_O);
endmodule
bind gio_port gio_port_sva i_gio_port_sva (.CLK_SYS_I, .SYS_RST_I, .CE_I, .WB_CYC_I, .WB_STB_I,
	.WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .PAD_IN_I,
	.PAD_O, .ALT_I, .ALT_IN_O, .VEC_FETCH_I, .EXT_IRQ_O);
`default_nettype wire

// [sim/gio_pads.sv]
// Model of the circuitry on the pins: external drivers and pull-ups.
// Assumes the bench never drives a pin the port drives.
`default_nettype none
module gio_pads (
	input wire logic clk_i, // Clock
	input wire gio_pkg::gio_pad_t pad_i, // Port drive
	input wire logic [7:0] ext_en_i, // External drive on
	input wire logic [7:0] ext_val_i, // External level
	output logic [7:0] lvl_o // Pin levels
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last_q = 8'h00;
	always_ff @(posedge clk_i) last_q <= lvl_o;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_i.oe[i]) lvl_o[i] = pad_i.out[i];
			else if (ext_en_i[i]) lvl_o[i] = ext_val_i[i];
			else if (pad_i.pull_en[i]) lvl_o[i] = 1'b1;
			else lvl_o[i] = ~last_q[i]; // Floating pin wanders
		end
	end
endmodule
`default_nettype wire

// [sim/gio_port_tb.sv]
// Self-checking bench for gio_port with a pin model and Wishbone master.
// Assumes the bound checker and the package are compiled first.
`default_nettype none
module gio_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, er;
	logic [7:0] adr = 8'h00, ext_en = 8'h00, ext_val = 8'h00, alt_in, pins;
	logic [31:0] wdat = 32'h0000_0000, dat_o, rd;
	logic [1:0] fetch = 2'h0, irq;
	gio_pkg::gio_alt_t alt = '0;
	gio_pkg::gio_pad_t pad;
	int num_errors = 0, checked = 0;
	always #25 clk = ~clk;
	gio_port i_gio_port (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err), .PAD_IN_I(pins), .PAD_O(pad),
		.ALT_I(alt), .ALT_IN_O(alt_in), .VEC_FETCH_I(fetch), .EXT_IRQ_O(irq));
	gio_pads i_gio_pads (.clk_i(clk), .pad_i(pad), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.lvl_o(pins));
	task automatic close_out;
		if (num_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		if (ack !== 1'b1 && err !== 1'b1) begin
			num_errors++;
			close_out();
		end
		rd = dat_o;
		er = err;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic wirq(input int g, input logic e);
		int n;
		n = 0;
		while (irq[g] !== e && n < 8) begin
			@(negedge clk);
			n++;
		end
		chk("irq", irq[g], e);
	endtask
	task automatic s_regs;
		wb(0, gio_pkg::ADDR_DIR, 0);
		chk("dir reset", rd, 0);
		wb(1, gio_pkg::ADDR_OPT, 32'h0000_00A5);
		wb(0, gio_pkg::ADDR_OPT, 0);
		chk("opt", rd, 32'h0000_00A5);
		wb(0, 8'h18, 0);
		chk("unmapped", er, 1);
	endtask
	task automatic s_modes;
		{ext_en, ext_val} <= 16'hFFA5;
		repeat (3) @(posedge clk);
		wb(0, gio_pkg::ADDR_DATA, 0);
		chk("input read", rd, 32'h0000_00A5);
		wb(1, gio_pkg::ADDR_DATA, 32'h0000_003C);
		chk("input undriven", pad.oe, 0);
		ext_en <= 8'h0F;
		wb(1, gio_pkg::ADDR_OPT, 32'h0000_00C3);
		wb(1, gio_pkg::ADDR_DIR, 32'h0000_00F0);
		chk("oe", pad.oe, 8'hC0);
		chk("drive low", pad.out & pad.oe, 0);
		chk("pull", pad.pull_en, 8'h03);
		wb(0, gio_pkg::ADDR_DATA, 0);
		chk("mixed read", rd, 32'h0000_0035);
		wb(1, gio_pkg::ADDR_DATA, 32'h0000_00FC);
		chk("drive high", pad.out & pad.oe, 8'hC0);
		chk("alt in", alt_in[7:4], 4'hF);
	endtask
	task automatic s_alt;
		ext_en <= 8'h0E;
		alt <= {8'h01, 8'h01, 8'h01, 8'h01};
		wb(1, gio_pkg::ADDR_OPT, 32'h0000_00C0);
		chk("alt drive", {pad.oe[0], pad.out[0]}, 2'b11);
		wb(0, gio_pkg::ADDR_DATA, 0);
		chk("alt read", rd, 32'h0000_00F5);
		alt <= '0;
	endtask
	task automatic s_irq;
		{ext_en, ext_val} <= 16'hFF00;
		wb(1, gio_pkg::ADDR_DIR, 0);
		wb(1, gio_pkg::ADDR_GROUP, 32'h0000_0002);
		wb(1, gio_pkg::ADDR_OPT, 32'h0000_0003);
		wb(1, gio_pkg::ADDR_SENS, 32'h0000_0009);
		wirq(0, 0);
		ext_val <= 8'h01;
		wirq(0, 1);
		chk("other group", irq[1], 0);
		@(posedge clk);
		fetch <= 2'b01;
		@(posedge clk);
		fetch <= 2'b00;
		wirq(0, 0);
		ext_val <= 8'h00;
		repeat (6) @(posedge clk);
		chk("rise only", irq, 0);
		ext_val <= 8'h02;
		repeat (6) @(posedge clk);
		chk("fall only", irq[1], 0);
		ext_val <= 8'h00;
		wirq(1, 1);
		wb(1, gio_pkg::ADDR_SENS, 32'h0000_000D);
		wirq(1, 0);
		ext_val <= 8'h02;
		wirq(1, 1);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		s_regs();
		s_modes();
		s_alt();
		s_irq();
		close_out();
	end
endmodule
`default_nettype wire
